// file: src/tcsdma_map.vh
// register map, field positions, reset values and fixed ranges of the dma block
`ifndef TCSDMA_MAP_VH
`define TCSDMA_MAP_VH

// register index inside one channel window (byte address bits 4:2)
`define TCSDMA_REG_SRC 3'h0
`define TCSDMA_REG_DST 3'h1
`define TCSDMA_REG_RLD 3'h2
`define TCSDMA_REG_CNT 3'h3
`define TCSDMA_REG_CTL 3'h4
`define TCSDMA_REG_SEL 3'h5
`define TCSDMA_REG_LAST 3'h5

// byte address bit that picks channel one (channel zero at 8'h00, channel one at 8'h20)
`define TCSDMA_CH_BIT 5

// control register fields
`define TCSDMA_CTL_EN 0
`define TCSDMA_CTL_REP 1
`define TCSDMA_CTL_USZ 2
`define TCSDMA_CTL_SFWD 3
`define TCSDMA_CTL_DFWD 4
`define TCSDMA_CTL_REQ 5
`define TCSDMA_CTL_SWT 6

// request source select codes
`define TCSDMA_SEL_SW 5'h00
`define TCSDMA_SEL_FALL 5'h01
`define TCSDMA_SEL_BOTH 5'h02
`define TCSDMA_SEL_PER0 5'h03
`define TCSDMA_SEL_PERN 5'h16

// reset values
`define TCSDMA_RST_PTR 20'h00000
`define TCSDMA_RST_CNT 16'h0000
`define TCSDMA_RST_SEL 5'h00

// own register range, never touched by a transfer
`define TCSDMA_PROT_LO 20'h00020
`define TCSDMA_PROT_HI 20'h0003F

`endif

// file: src/tcsdma_top.v
// two-channel cycle-stealing dma controller with a wishbone register slave
`timescale 1ns/1ns
`default_nettype none
`include "tcsdma_map.vh"

// Operation
// - two channels steal bus ahead of cpu
// - request from software bit or interrupt signal
// - active channel moves one unit per request
// - requests arriving too fast merge into one
// - forward or fixed ends, never both forward
// - own register range never a transfer target
// - sixteen-bit counter limits one programmed transfer
// - pin edges, timers, serial, converter, software sources
// - channel zero wins simultaneous requests
// - single mode underflow clears enable
// - repeat mode underflow reloads, stays active
// - underflow raises the channel interrupt request
// - first transfer reloads forward pointer and counter
// - fixed registers writable only while disabled
// - reads always allowed; active forward shows pointer
// - request bit set by event, cleared at start
// - rewriting enable one restarts the channel
// - one cpu access between channel transfers
// - read then write; odd word splits
module tcsdma_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ext_irq_pin_a_i,
  input wire ext_irq_pin_b_i,
  input wire [19:0] periph_req_i,
  output reg bus_hold_o,
  output reg mem_cyc_o,
  output reg mem_we_o,
  output reg [19:0] mem_addr_o,
  output reg [15:0] mem_wdata_o,
  output reg mem_wide_o,
  input wire mem_ack_i,
  input wire [15:0] mem_rdata_i,
  output wire [1:0] dma_irq_o
);
  localparam [2:0] S_IDLE = 3'h0; // waiting for a request
  localparam [2:0] S_RD = 3'h1; // source read
  localparam [2:0] S_WR = 3'h2; // destination write
  localparam [2:0] S_GAP = 3'h3; // bus handed back to the cpu

  reg [2:0] state; // transfer sequencer state
  reg ch; // channel being served
  reg [19:0] dst_q; // latched destination address
  reg u16; // latched unit size
  reg phase; // second byte of a split word
  reg [15:0] dat; // data held between read and write
  reg [1:0] start; // start pulse per channel
  reg [1:0] done; // done pulse per channel
  reg [15:0] nd; // data after this read beat
  wire [2:0] idx; // register index from address
  wire mapped; // address hits a register
  wire wb_wr; // register write takes effect
  wire wr0; // write to channel zero
  wire wr1; // write to channel one
  wire [31:0] rd0; // channel zero read data
  wire [31:0] rd1; // channel one read data
  wire pend0; // channel zero ready to go
  wire pend1; // channel one ready to go
  wire [19:0] src0; // channel zero source
  wire [19:0] src1; // channel one source
  wire [19:0] dst0; // channel zero destination
  wire [19:0] dst1; // channel one destination
  wire w16_0; // channel zero word units
  wire w16_1; // channel one word units
  wire blocked; // current address lies in own register range
  wire ack_eff; // beat finished, real or suppressed
  wire split; // word at odd address moves as two bytes
  wire [19:0] addr_nx; // next byte address of a split word
  wire [19:0] ch_src; // chosen channel source
  wire [19:0] ch_dst; // chosen channel destination
  wire ch_u16; // chosen channel unit size

  // true when an address falls inside the controller's own registers
  function prot;
    input [19:0] a;
    begin
      prot = (a >= `TCSDMA_PROT_LO) && (a <= `TCSDMA_PROT_HI);
    end
  endfunction

  assign idx = wb_adr_i[4:2];
  assign mapped = (wb_adr_i[7:6] == 2'b00) && (idx <= `TCSDMA_REG_LAST);
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && mapped;
  assign wr0 = wb_wr && !wb_adr_i[`TCSDMA_CH_BIT];
  assign wr1 = wb_wr && wb_adr_i[`TCSDMA_CH_BIT];
  // channel zero has priority when both wait
  assign ch_src = pend0 ? src0 : src1;
  assign ch_dst = pend0 ? dst0 : dst1;
  assign ch_u16 = pend0 ? w16_0 : w16_1;
  assign blocked = prot(mem_addr_o);
  assign ack_eff = mem_ack_i || blocked;
  assign split = u16 && mem_addr_o[0];
  assign addr_nx = mem_addr_o + 20'h00001;

  tcsdma_chan u_channel_zero (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr0),
    .idx_i(idx),
    .wdat_i(wb_dat_i),
    .sel_i(wb_sel_i),
    .ext_i(ext_irq_pin_a_i),
    .periph_i(periph_req_i),
    .start_i(start[0]),
    .done_i(done[0]),
    .pend_o(pend0),
    .src_o(src0),
    .dst_o(dst0),
    .unit16_o(w16_0),
    .rdat_o(rd0),
    .irq_o(dma_irq_o[0])
  );

  tcsdma_chan u_channel_one (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr1),
    .idx_i(idx),
    .wdat_i(wb_dat_i),
    .sel_i(wb_sel_i),
    .ext_i(ext_irq_pin_b_i),
    .periph_i(periph_req_i),
    .start_i(start[1]),
    .done_i(done[1]),
    .pend_o(pend1),
    .src_o(src1),
    .dst_o(dst1),
    .unit16_o(w16_1),
    .rdat_o(rd1),
    .irq_o(dma_irq_o[1])
  );

  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (!mapped) begin
          wb_dat_o <= 32'h00000000;
        end else begin
          wb_dat_o <= wb_adr_i[`TCSDMA_CH_BIT] ? rd1 : rd0;
        end
      end
    end
  end

  // read data placement for the current beat; blocked reads give zero
  always @* begin
    nd = dat;
    if (!u16) begin
      nd[7:0] = blocked ? 8'h00 : mem_rdata_i[7:0];
    end else if (!split && !phase) begin
      nd = blocked ? 16'h0000 : mem_rdata_i;
    end else if (!phase) begin
      nd[7:0] = blocked ? 8'h00 : mem_rdata_i[7:0];
    end else begin
      nd[15:8] = blocked ? 8'h00 : mem_rdata_i[7:0];
    end
  end

  // transfer sequencer: read, write, then one cycle back to the cpu
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      ch <= 1'b0;
      dst_q <= `TCSDMA_RST_PTR;
      u16 <= 1'b0;
      phase <= 1'b0;
      dat <= 16'h0000;
      start <= 2'b00;
      done <= 2'b00;
      bus_hold_o <= 1'b0;
      mem_cyc_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= `TCSDMA_RST_PTR;
      mem_wdata_o <= 16'h0000;
      mem_wide_o <= 1'b0;
    end else begin
      start <= 2'b00;
      done <= 2'b00;
      case (state)
        S_IDLE: begin
          // one pending flag per channel, so bursts collapse to one unit
          if (pend0 || pend1) begin
            ch <= !pend0;
            start <= pend0 ? 2'b01 : 2'b10;
            bus_hold_o <= 1'b1;
            dst_q <= ch_dst;
            u16 <= ch_u16;
            phase <= 1'b0;
            mem_addr_o <= ch_src;
            mem_we_o <= 1'b0;
            mem_wide_o <= ch_u16 && !ch_src[0];
            mem_cyc_o <= !prot(ch_src);
            state <= S_RD;
          end
        end
        S_RD: begin
          if (ack_eff) begin
            dat <= nd;
            if (split && !phase) begin
              phase <= 1'b1;
              mem_addr_o <= addr_nx;
              mem_cyc_o <= !prot(addr_nx);
            end else begin
              phase <= 1'b0;
              mem_addr_o <= dst_q;
              mem_we_o <= 1'b1;
              mem_wide_o <= u16 && !dst_q[0];
              mem_wdata_o <= (u16 && dst_q[0]) ? {8'h00, nd[7:0]} : nd;
              mem_cyc_o <= !prot(dst_q);
              state <= S_WR;
            end
          end
        end
        S_WR: begin
          if (ack_eff) begin
            if (split && !phase) begin
              phase <= 1'b1;
              mem_addr_o <= addr_nx;
              mem_wdata_o <= {8'h00, dat[15:8]};
              mem_cyc_o <= !prot(addr_nx);
            end else begin
              mem_cyc_o <= 1'b0;
              mem_we_o <= 1'b0;
              bus_hold_o <= 1'b0;
              done <= ch ? 2'b10 : 2'b01;
              state <= S_GAP;
            end
          end
        end
        S_GAP: begin
          // the cpu owns the bus for this cycle
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// one channel: registers, request flag, pointers and transfer counter
module tcsdma_chan (
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [2:0] idx_i,
  input wire [31:0] wdat_i,
  input wire [3:0] sel_i,
  input wire ext_i,
  input wire [19:0] periph_i,
  input wire start_i,
  input wire done_i,
  output wire pend_o,
  output wire [19:0] src_o,
  output wire [19:0] dst_o,
  output wire unit16_o,
  output reg [31:0] rdat_o,
  output reg irq_o
);
  reg [19:0] src_r; // programmed source pointer
  reg [19:0] dst_r; // programmed destination pointer
  reg [15:0] rld; // counter reload value, 16 bits wide
  reg [15:0] cnt; // live transfer counter, 16 bits wide
  reg [19:0] fwd; // live forward address pointer
  reg en; // channel active
  reg rep; // repeat mode
  reg usz; // 1 = 8-bit units, 0 = 16-bit units
  reg sfwd; // source walks forward
  reg dfwd; // destination walks forward
  reg req; // pending request flag
  reg first; // next start reloads pointer and counter
  reg [4:0] sel_r; // request source select
  reg ext_q; // last sampled pin level
  wire [31:0] ctl_now; // control word as read
  wire [31:0] wctl; // control word after byte-lane merge
  wire [31:0] next_src; // source pointer word after byte-lane merge
  wire [31:0] next_dst; // destination pointer word after byte-lane merge
  wire [31:0] next_rld; // reload word after byte-lane merge
  wire [31:0] next_sel; // select word after byte-lane merge
  wire [4:0] pidx; // peripheral index from select code
  wire trig; // one request event this cycle
  wire sw_hit; // software trigger write
  wire [19:0] fwd_base; // programmed pointer that walks forward
  wire [19:0] fwd_val; // pointer value that the next unit uses
  wire [19:0] step; // unit size in bytes

  // byte-lane merge of a write into an old value
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] s;
    reg [31:0] m;
    begin
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      merge = (old_v & ~m) | (new_v & m);
    end
  endfunction

  assign ctl_now = {25'h0000000, 1'b0, req, dfwd, sfwd, usz, rep, en};
  assign wctl = merge(ctl_now, wdat_i, sel_i);
  // merged write words; only the low field bits are kept on a write
  assign next_src = merge({12'h000, src_r}, wdat_i, sel_i);
  assign next_dst = merge({12'h000, dst_r}, wdat_i, sel_i);
  assign next_rld = merge({16'h0000, rld}, wdat_i, sel_i);
  assign next_sel = merge({27'h0000000, sel_r}, wdat_i, sel_i);
  assign sw_hit = wr_i && (idx_i == `TCSDMA_REG_CTL) && wctl[`TCSDMA_CTL_SWT];
  assign pidx = sel_r - `TCSDMA_SEL_PER0;
  // pick the request source; edge modes use the synchronous pin sample
  assign trig = ((sel_r == `TCSDMA_SEL_SW) && sw_hit) ||
    ((sel_r == `TCSDMA_SEL_FALL) && ext_q && !ext_i) ||
    ((sel_r == `TCSDMA_SEL_BOTH) && (ext_q != ext_i)) ||
    ((sel_r >= `TCSDMA_SEL_PER0) && (sel_r <= `TCSDMA_SEL_PERN) && periph_i[pidx]);
  assign fwd_base = sfwd ? src_r : dst_r;
  assign fwd_val = first ? fwd_base : fwd;
  assign step = usz ? 20'h00001 : 20'h00002;
  // a request only counts while the channel is active
  assign pend_o = req && en;
  assign src_o = sfwd ? fwd_val : src_r;
  assign dst_o = dfwd ? fwd_val : dst_r;
  assign unit16_o = !usz;

  // register reads; an active forward pointer reads the live value
  always @* begin
    case (idx_i)
      `TCSDMA_REG_SRC: rdat_o = {12'h000, (en && sfwd) ? fwd_val : src_r};
      `TCSDMA_REG_DST: rdat_o = {12'h000, (en && dfwd) ? fwd_val : dst_r};
      `TCSDMA_REG_RLD: rdat_o = {16'h0000, rld};
      `TCSDMA_REG_CNT: rdat_o = {16'h0000, cnt};
      `TCSDMA_REG_CTL: rdat_o = ctl_now;
      `TCSDMA_REG_SEL: rdat_o = {27'h0000000, sel_r};
      default: rdat_o = 32'h00000000;
    endcase
  end

  // channel state
  always @(posedge clk_i) begin
    if (rst_i) begin
      src_r <= `TCSDMA_RST_PTR;
      dst_r <= `TCSDMA_RST_PTR;
      fwd <= `TCSDMA_RST_PTR;
      rld <= `TCSDMA_RST_CNT;
      cnt <= `TCSDMA_RST_CNT;
      en <= 1'b0;
      rep <= 1'b0;
      usz <= 1'b0;
      sfwd <= 1'b0;
      dfwd <= 1'b0;
      req <= 1'b0;
      first <= 1'b0;
      sel_r <= `TCSDMA_RST_SEL;
      ext_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      ext_q <= ext_i;
      irq_o <= 1'b0;
      // first unit after activation reloads pointer and counter
      if (start_i && first) begin
        first <= 1'b0;
        fwd <= fwd_base;
        cnt <= rld;
      end
      // unit finished: count down, walk the forward pointer
      if (done_i) begin
        fwd <= fwd + step;
        if (cnt == 16'h0000) begin
          irq_o <= 1'b1;
          cnt <= rld;
          if (rep) begin
            fwd <= fwd_base;
          end else begin
            en <= 1'b0;
          end
        end else begin
          cnt <= cnt - 16'h0001;
        end
      end
      // software register writes
      if (wr_i) begin
        case (idx_i)
          `TCSDMA_REG_SRC: begin
            if (sfwd || !en) begin
              src_r <= next_src[19:0];
            end
          end
          `TCSDMA_REG_DST: begin
            if (dfwd || !en) begin
              dst_r <= next_dst[19:0];
            end
          end
          `TCSDMA_REG_RLD: rld <= next_rld[15:0];
          `TCSDMA_REG_CTL: begin
            en <= wctl[`TCSDMA_CTL_EN];
            if (wctl[`TCSDMA_CTL_EN]) begin
              first <= 1'b1;
            end
            rep <= wctl[`TCSDMA_CTL_REP];
            usz <= wctl[`TCSDMA_CTL_USZ];
            sfwd <= wctl[`TCSDMA_CTL_SFWD];
            // both directions forward is refused: destination stays fixed
            dfwd <= wctl[`TCSDMA_CTL_DFWD] && !wctl[`TCSDMA_CTL_SFWD];
          end
          `TCSDMA_REG_SEL: sel_r <= next_sel[4:0];
          default: begin
          end
        endcase
      end
      // request flag: a new event wins over start and over a software clear
      if (trig) begin
        req <= 1'b1;
      end else if (start_i) begin
        req <= 1'b0;
      end else if (wr_i && (idx_i == `TCSDMA_REG_CTL) && !wctl[`TCSDMA_CTL_REQ]) begin
        req <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/tcsdma_top_assertions.sv
// port assertions for the two-channel dma controller
`timescale 1ns/1ns
`default_nettype none
module tcsdma_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic bus_hold_o,
  input wire logic mem_cyc_o,
  input wire logic mem_we_o,
  input wire logic [19:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [1:0] dma_irq_o
);
  // all checks on the bus clock, muted in reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("register ack without request");
  beat_hold_a: assert property (mem_cyc_o && !mem_ack_i |=>
    mem_cyc_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory beat not held");
  bus_owned_a: assert property (mem_cyc_o |-> bus_hold_o)
    else $error("memory access without bus");
  own_range_a: assert property (mem_cyc_o |->
    (mem_addr_o < 20'h00020 || mem_addr_o > 20'h0003F))
    else $error("access into own registers");
  read_first_a: assert property ($rose(bus_hold_o) |-> !mem_we_o)
    else $error("transfer began with a write");
  cpu_gap_a: assert property ($fell(bus_hold_o) |=> !bus_hold_o)
    else $error("no bus gap between transfers");
  irq_pulse_a: assert property (dma_irq_o[0] |=> !dma_irq_o[0])
    else $error("irq pulse too long");
  irq_time_a: assert property (|dma_irq_o |-> !bus_hold_o && $past(bus_hold_o, 2))
    else $error("irq not at transfer end");
endmodule
`default_nettype wire

// file: verification/tcsdma_mem.sv
// shared memory model: answers each beat after a set number of idle cycles
`timescale 1ns/1ns
`default_nettype none
module tcsdma_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic [19:0] addr_i,
  input wire logic [3:0] slow_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  logic [3:0] wt; // idle cycles spent on the current beat
  // one-cycle ack per beat; data lines toggle while not answering
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wt <= 4'h0;
      rdata_o <= 16'hA5A5;
    end else if (!ack_o && cyc_i && wt == slow_i) begin
      ack_o <= 1'b1;
      wt <= 4'h0;
      rdata_o <= {addr_i[7:0] + 8'h01, addr_i[7:0]} ^ 16'h5A5A;
    end else begin
      ack_o <= 1'b0;
      wt <= (cyc_i && !ack_o) ? wt + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// file: verification/tcsdma_tb.sv
// self-checking bench for the dma controller with a memory model
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i = 1'b0; // bus clock
  logic rst_i = 1'b1; // synchronous reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pa = 1'b1, pb = 1'b1; // bus request, pins
  logic [7:0] adr = 8'h00;
  logic [3:0] bs = 4'hF, slow = 4'h0; // byte lanes, memory wait
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [19:0] pr = 20'h0, maddr;
  logic ack, hold, mcyc, mwe, mwide, mack, hq = 1'b0;
  logic [15:0] mwd, mrd;
  logic [1:0] irq;
  int n_mismatch = 0, checked = 0, nx = 0, n0 = 0, n1, ni[2] = '{0, 0};
  logic [19:0] qa[$]; // write beat addresses
  logic [15:0] qd[$]; // write beat data
  always #5 clk_i = ~clk_i;
  tcsdma_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(bs), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_irq_pin_a_i(pa), .ext_irq_pin_b_i(pb), .periph_req_i(pr), .bus_hold_o(hold),
    .mem_cyc_o(mcyc), .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwd),
    .mem_wide_o(mwide), .mem_ack_i(mack), .mem_rdata_i(mrd), .dma_irq_o(irq));
  tcsdma_mem mem (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(mcyc), .addr_i(maddr), .slow_i(slow),
    .ack_o(mack), .rdata_o(mrd));
  // log write beats, count finished transfers and underflow pulses
  always @(posedge clk_i) begin
    hq <= hold;
    if (mack && mwe) begin
      qa.push_back(maddr);
      qd.push_back(mwide ? mwd : {8'h00, mwd[7:0]});
    end
    if (hq && !hold) nx <= nx + 1;
    ni[0] <= ni[0] + irq[0];
    ni[1] <= ni[1] + irq[1];
  end
  task automatic final_report;
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        final_report;
      end
      @(posedge clk_i);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // wait for k more transfers, then let the pulses settle
  task automatic xw(input int k);
    int n;
    n = 0;
    while (nx < n0 + k) begin
      n++;
      if (n > 500) begin
        n_mismatch++;
        final_report;
      end
      @(posedge clk_i);
    end
    n0 += k;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pp(input int k);
    pr[k] <= 1'b1;
    @(posedge clk_i);
    pr[k] <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [7:0] pt(input logic [19:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h10, 32'h0, "ctl0");
    rd(8'h34, 32'h0, "sel1");
    wb(1'b1, 8'hC0, 32'hFFFFFFFF);
    rd(8'hC0, 32'h0, "unmapped");
    // channel zero: byte units, forward source, single mode
    wb(1'b1, 8'h00, 32'h10);
    wb(1'b1, 8'h04, 32'h80);
    wb(1'b1, 8'h08, 32'h0F02);
    bs <= 4'h2;
    wb(1'b1, 8'h08, 32'h0);
    bs <= 4'hF;
    rd(8'h08, 32'h2, "lanes");
    wb(1'b1, 8'h14, 32'h3);
    wb(1'b1, 8'h10, 32'h0D);
    pp(0);
    xw(1);
    rd(8'h00, 32'h11, "fwd ptr");
    rd(8'h0C, 32'h1, "count");
    chk("wr addr", 32'h80, qa[$]);
    chk("wr data", pt(20'h10), qd[$]);
    wb(1'b1, 8'h04, 32'h99);
    rd(8'h04, 32'h80, "fixed ptr");
    pp(0);
    xw(1);
    rd(8'h10, 32'h0D, "ctl mid");
    pp(0);
    xw(1);
    rd(8'h10, 32'h0C, "ctl end");
    chk("irq0", 1, ni[0]);
    chk("last data", pt(20'h12), qd[$]);
    // request flag while idle
    pp(0);
    rd(8'h10, 32'h2C, "req set");
    wb(1'b1, 8'h10, 32'h0C);
    rd(8'h10, 32'h0C, "req clr");
    wb(1'b1, 8'h10, 32'h2C);
    rd(8'h10, 32'h0C, "req kept");
    chk("idle", n0, nx);
    // channel one: words at odd addresses, forward dest, repeat mode
    wb(1'b1, 8'h20, 32'h11);
    wb(1'b1, 8'h24, 32'h91);
    wb(1'b1, 8'h28, 32'h1);
    wb(1'b1, 8'h34, 32'h1);
    wb(1'b1, 8'h30, 32'h13);
    pb <= 1'b0;
    xw(1);
    chk("split addr", 32'h91, qa[$-1]);
    chk("split data", pt(20'h12), qd[$]);
    pb <= 1'b1;
    repeat (6) @(posedge clk_i);
    pb <= 1'b0;
    xw(1);
    chk("irq1", 1, ni[1]);
    rd(8'h30, 32'h13, "rep ctl");
    // both pins fall together
    pb <= 1'b1;
    wb(1'b1, 8'h00, 32'h40);
    wb(1'b1, 8'h14, 32'h1);
    wb(1'b1, 8'h10, 32'h0D);
    pa <= 1'b0;
    pb <= 1'b0;
    xw(2);
    chk("first", 32'h80, qa[$-2]);
    chk("reload", 32'h91, qa[$-1]);
    // rewriting enable restarts the pointer
    pa <= 1'b1;
    wb(1'b1, 8'h10, 32'h0D);
    pa <= 1'b0;
    xw(1);
    chk("restart", pt(20'h40), qd[$]);
    // fixed end inside the own register range
    pa <= 1'b1;
    wb(1'b1, 8'h10, 32'h0C);
    wb(1'b1, 8'h04, 32'h25);
    wb(1'b1, 8'h10, 32'h0D);
    n1 = qa.size();
    pa <= 1'b0;
    xw(1);
    chk("own range", n1, qa.size());
    wb(1'b1, 8'h10, 32'h18);
    rd(8'h10, 32'h08, "both fwd");
    // every peripheral source, both edges, then software
    wb(1'b1, 8'h04, 32'h80);
    wb(1'b1, 8'h08, 32'hFF);
    wb(1'b1, 8'h10, 32'h0F);
    for (int k = 0; k < 20; k++) begin
      wb(1'b1, 8'h14, k + 3);
      pp(k);
      xw(1);
    end
    wb(1'b1, 8'h14, 32'h2);
    pa <= 1'b1;
    xw(1);
    pa <= 1'b0;
    xw(1);
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h10, 32'h4F);
    xw(1);
    chk("sources", n0, nx);
    // fast requests against a slow memory
    wb(1'b1, 8'h14, 32'h3);
    slow <= 4'h8;
    pp(0);
    pp(0);
    pp(0);
    repeat (150) @(posedge clk_i);
    chk("merged", 1, (nx - n0 > 0) && (nx - n0 < 3));
    final_report;
  end
endmodule
bind tcsdma_top tcsdma_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .bus_hold_o(bus_hold_o), .mem_cyc_o(mem_cyc_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .dma_irq_o(dma_irq_o));
`default_nettype wire
